/* File: hdl/pevb_params.svh */
`ifndef PEVB_PARAMS_SVH
`define PEVB_PARAMS_SVH

// ==========================================================================
// coprocessor coordinates of the filter and event type registers
`define PEVB_CP_NUM 4'hf
`define PEVB_CP_OPC1 3'h0
`define PEVB_CP_CRN 4'h9
`define PEVB_CP_CRM 4'hd
`define PEVB_CP_OPC2 3'h1
// counter selection value that steers the shared slot to the filter
`define PEVB_SEL_CYCLE 5'h1f

// ==========================================================================
// filter register fields and reset value, event type select width and reset value
`define PEVB_FLT_P 31
`define PEVB_FLT_U 30
`define PEVB_FLT_NSP 29
`define PEVB_FLT_NSUSR 28
`define PEVB_FLT_RESET 4'h0
`define PEVB_EVT_W 8
`define PEVB_EVT_RESET 8'h00

// ==========================================================================
// event numbers
`define PEVB_EV_L1I_REFILL 8'h01
`define PEVB_EV_ITLB_REFILL 8'h02
`define PEVB_EV_L1D_REFILL 8'h03
`define PEVB_EV_L1D_ACCESS 8'h04
`define PEVB_EV_DTLB_REFILL 8'h05
`define PEVB_EV_LOAD 8'h06
`define PEVB_EV_STORE 8'h07
`define PEVB_EV_INSTR 8'h08
`define PEVB_EV_EXC_TAKEN 8'h09
`define PEVB_EV_EXC_RET 8'h0a
`define PEVB_EV_CTXID 8'h0b
`define PEVB_EV_PC_WRITE 8'h0c
`define PEVB_EV_IMM_BR 8'h0d
`define PEVB_EV_PROC_RET 8'h0e
`define PEVB_EV_UNALIGNED 8'h0f
`define PEVB_EV_BR_MISP 8'h10
`define PEVB_EV_BR_PRED 8'h12
`define PEVB_EV_DMEM 8'h13
`define PEVB_EV_ICACHE 8'h14
`define PEVB_EV_DEVICT 8'h15
`define PEVB_EV_IRQ 8'h86
`define PEVB_EV_FIQ 8'h87
`define PEVB_EV_EXT_REQ 8'hc0
`define PEVB_EV_EXT_NC 8'hc1
`define PEVB_EV_PF_FILL 8'hc2
`define PEVB_EV_PF_DROP 8'hc3
`define PEVB_EV_RA_ENTER 8'hc4
`define PEVB_EV_RA_MODE 8'hc5
`define PEVB_EV_SB_STALL 8'hc9
// event bus width; bit 28 stays reserved
`define PEVB_BUS_W 30
`define PEVB_BIT_RSVD 28

`endif

/* File: hdl/pevb_pkg.sv */
`include "pevb_params.svh"

package pevb_pkg;

    // ======================================================================
    // target of a decoded coprocessor transfer
    typedef enum logic [1:0] {
        PEVB_ACC_NONE,
        PEVB_ACC_FILTER,
        PEVB_ACC_EVTYPE
    } pevb_acc_e;

    typedef logic [`PEVB_BUS_W-1:0] pevb_bus_t;

    // ======================================================================
    // event number to bus bit; hit low for reserved or bus-less numbers
    function automatic logic [5:0] pevb_ev_to_bit(input logic [7:0] num);
        logic [5:0] r;
        r = 6'h00;
        case (num)
            `PEVB_EV_L1I_REFILL: r = 6'h20;
            `PEVB_EV_ITLB_REFILL: r = 6'h21;
            `PEVB_EV_L1D_REFILL: r = 6'h22;
            `PEVB_EV_L1D_ACCESS: r = 6'h23;
            `PEVB_EV_DTLB_REFILL: r = 6'h24;
            `PEVB_EV_LOAD: r = 6'h25;
            `PEVB_EV_STORE: r = 6'h26;
            `PEVB_EV_INSTR: r = 6'h27;
            `PEVB_EV_EXC_TAKEN: r = 6'h28;
            `PEVB_EV_EXC_RET: r = 6'h29;
            `PEVB_EV_CTXID: r = 6'h2a;
            `PEVB_EV_PC_WRITE: r = 6'h2b;
            `PEVB_EV_IMM_BR: r = 6'h2c;
            `PEVB_EV_PROC_RET: r = 6'h2d;
            `PEVB_EV_UNALIGNED: r = 6'h2e;
            `PEVB_EV_BR_MISP: r = 6'h2f;
            `PEVB_EV_BR_PRED: r = 6'h30;
            `PEVB_EV_DMEM: r = 6'h31;
            `PEVB_EV_ICACHE: r = 6'h32;
            `PEVB_EV_DEVICT: r = 6'h33;
            `PEVB_EV_IRQ: r = 6'h34;
            `PEVB_EV_FIQ: r = 6'h35;
            `PEVB_EV_EXT_REQ: r = 6'h36;
            `PEVB_EV_EXT_NC: r = 6'h37;
            `PEVB_EV_PF_FILL: r = 6'h38;
            `PEVB_EV_PF_DROP: r = 6'h39;
            `PEVB_EV_RA_ENTER: r = 6'h3a;
            `PEVB_EV_RA_MODE: r = 6'h3b;
            `PEVB_EV_SB_STALL: r = 6'h3d;
            default: r = 6'h00;
        endcase
        return r;
    endfunction

endpackage

/* File: hdl/pevb_evt_mux.sv */
`include "pevb_params.svh"

// routes the bus bit chosen by one event type select to one counter
module pevb_evt_mux (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // selection and bus
    input wire logic [`PEVB_EVT_W-1:0] evt_sel,
    input wire pevb_pkg::pevb_bus_t event_bus,
    // one-cycle count strobe
    output logic count_q
);

    logic [5:0] map;
    logic count_d;

    // ======================================================================
    // decode; reserved numbers give no strobe at all
    always_comb begin
        map = pevb_pkg::pevb_ev_to_bit(evt_sel);
        count_d = map[5] && event_bus[map[4:0]];
    end

    // registered so the counter sees exactly one edge per occurrence
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 1'b0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule

/* File: hdl/pevb_event_bus.sv */
`include "pevb_params.svh"


module pevb_event_bus #(
    parameter int NUM_COUNTERS = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,

    // instruction side events
    input wire logic ev_icache_refill,
    input wire logic ev_itlb_refill,
    input wire logic ev_icache_access,
    input wire logic ev_instr_retired,

    // data side events
    input wire logic ev_dcache_refill,
    input wire logic ev_dcache_access,
    input wire logic ev_dtlb_refill,
    input wire logic ev_dtlb_refill_excluded,
    input wire logic ev_load_accepted,
    input wire logic ev_store_accepted,
    input wire logic ev_swap_accepted,
    input wire logic ev_unaligned,
    input wire logic ev_dmem_access,
    input wire logic ev_dcache_evict,

    // exception events
    input wire logic ev_exc_taken,
    input wire logic ev_irq_taken,
    input wire logic ev_fiq_taken,
    input wire logic ev_load_multiple_pc_user,
    input wire logic ev_return_from_exception,
    input wire logic ev_dp_flags_pc_write,

    // program flow events
    input wire logic ev_context_id_write,
    input wire logic ev_pc_write,
    input wire logic ev_imm_branch,
    input wire logic ev_proc_return,
    input wire logic ev_branch_mispredict,
    input wire logic ev_branch_predictable,

    // memory system events
    input wire logic ev_ext_request,
    input wire logic ev_ext_noncacheable,
    input wire logic ev_prefetch_fill,
    input wire logic ev_prefetch_drop,
    input wire logic read_alloc_mode,
    input wire logic ev_store_buffer_stall,

    // processor state for the cycle filter, counter selection and overflow request
    input wire logic cpu_privileged,
    input wire logic cpu_nonsecure,
    input wire logic [4:0] counter_select,
    input wire logic counter_overflow_irq,

    // coprocessor transfer port
    input wire logic cp_valid,
    input wire logic cp_write,
    input wire logic [3:0] cp_num,
    input wire logic [2:0] cp_opc1,
    input wire logic [3:0] cp_crn,
    input wire logic [3:0] cp_crm,
    input wire logic [2:0] cp_opc2,
    input wire logic [31:0] cp_wdata,
    output logic cp_hit_q,
    output logic [31:0] cp_rdata_q,

    // results
    output pevb_pkg::pevb_bus_t event_pulse_bus,
    output logic [NUM_COUNTERS-1:0] counter_event_q,
    output logic cycle_count_allow_q,
    output logic monitor_interrupt_out
);

    // ======================================================================
    // declarations
    pevb_pkg::pevb_bus_t bus_d;
    pevb_pkg::pevb_bus_t bus_q;
    logic ra_mode_q;
    logic exc_ret;

    logic flt_p_q;
    logic flt_u_q;
    logic flt_nsp_q;
    logic flt_nsusr_q;

    logic [`PEVB_EVT_W-1:0] evt_sel_q [NUM_COUNTERS];
    pevb_pkg::pevb_acc_e acc;
    logic coord_hit;
    logic [4:0] ctr_idx;

    logic allow_d;

    logic irq_q;
    logic [31:0] rdata_d;

    // ======================================================================
    // event bus assembly
    // an exception return is any of the three return forms
    assign exc_ret = ev_load_multiple_pc_user || ev_return_from_exception ||
                     ev_dp_flags_pc_write;

    // every source is a one-cycle strobe except the read-allocate level,
    // which is meant to be counted once per cycle spent in the mode
    always_comb begin
        bus_d = '0;

        bus_d[0] = ev_icache_refill;
        bus_d[1] = ev_itlb_refill;
        bus_d[2] = ev_dcache_refill;

        bus_d[3] = ev_dcache_access;
        // preload, maintenance and translation misses are not refills here
        bus_d[4] = ev_dtlb_refill && !ev_dtlb_refill_excluded;

        // a swap is both a read and a write
        bus_d[5] = ev_load_accepted || ev_swap_accepted;
        bus_d[6] = ev_store_accepted || ev_swap_accepted;

        bus_d[7] = ev_instr_retired;
        // interrupts are exceptions too, so they also hit the general bit
        bus_d[8] = ev_exc_taken || ev_irq_taken || ev_fiq_taken;

        bus_d[9] = exc_ret;
        bus_d[10] = ev_context_id_write;
        bus_d[11] = ev_pc_write;
        bus_d[12] = ev_imm_branch;
        bus_d[13] = ev_proc_return && !exc_ret;

        bus_d[14] = ev_unaligned;
        bus_d[15] = ev_branch_mispredict;
        bus_d[16] = ev_branch_predictable;

        bus_d[17] = ev_dmem_access;
        bus_d[18] = ev_icache_access;
        bus_d[19] = ev_dcache_evict;

        bus_d[20] = ev_irq_taken;
        bus_d[21] = ev_fiq_taken;

        // a non-cacheable request is still an external request
        bus_d[22] = ev_ext_request || ev_ext_noncacheable;
        bus_d[23] = ev_ext_noncacheable;
        bus_d[24] = ev_prefetch_fill;
        bus_d[25] = ev_prefetch_drop;

        // entry is the rising edge of the mode level, so one pulse only
        bus_d[26] = read_alloc_mode && !ra_mode_q;
        bus_d[27] = read_alloc_mode;

        bus_d[`PEVB_BIT_RSVD] = 1'b0;
        bus_d[29] = ev_store_buffer_stall;
    end

    // one register stage: each bus bit follows its source one clock later
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_q <= '0;
        end else begin
            bus_q <= bus_d;
        end
    end

    // previous read-allocate level for the entry edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ra_mode_q <= 1'b0;
        end else begin
            ra_mode_q <= read_alloc_mode;
        end
    end

    // no logic after the register stage
    assign event_pulse_bus = bus_q;

    // ======================================================================
    // per-counter event routing
    genvar gi;

    generate
        for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_ctr
            pevb_evt_mux u_mux (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .evt_sel(evt_sel_q[gi]),
                .event_bus(bus_q),
                .count_q(counter_event_q[gi])
            );
        end
    endgenerate

    // ======================================================================
    // coprocessor decode
    // the filter and the event type select share one coordinate; the
    // counter selection decides which one a transfer reaches
    assign coord_hit = cp_valid && cp_num == `PEVB_CP_NUM &&
                       cp_opc1 == `PEVB_CP_OPC1 && cp_crn == `PEVB_CP_CRN &&
                       cp_crm == `PEVB_CP_CRM && cp_opc2 == `PEVB_CP_OPC2;

    assign ctr_idx = counter_select;

    always_comb begin
        acc = pevb_pkg::PEVB_ACC_NONE;
        if (coord_hit) begin
            if (counter_select == `PEVB_SEL_CYCLE) begin
                acc = pevb_pkg::PEVB_ACC_FILTER;
            end else if (ctr_idx < 5'(NUM_COUNTERS)) begin
                acc = pevb_pkg::PEVB_ACC_EVTYPE;
            end
        end
    end

    // ======================================================================
    // cycle count filter register
    // reset loads zero, and zero means count everywhere; there is only
    // one copy, so both security states see the same bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {flt_p_q, flt_u_q, flt_nsp_q, flt_nsusr_q} <= `PEVB_FLT_RESET;
        end else if (acc == pevb_pkg::PEVB_ACC_FILTER && cp_write) begin
            flt_p_q <= cp_wdata[`PEVB_FLT_P];
            flt_u_q <= cp_wdata[`PEVB_FLT_U];
            flt_nsp_q <= cp_wdata[`PEVB_FLT_NSP];
            flt_nsusr_q <= cp_wdata[`PEVB_FLT_NSUSR];
        end
    end

    // ======================================================================
    // event type select registers
    // only the low eight bits are kept, the rest is dropped on write
    generate
        for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_evt
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    evt_sel_q[gi] <= `PEVB_EVT_RESET;
                end else if (acc == pevb_pkg::PEVB_ACC_EVTYPE && cp_write &&
                             ctr_idx == 5'(gi)) begin
                    evt_sel_q[gi] <= cp_wdata[`PEVB_EVT_W-1:0];
                end
            end
        end
    endgenerate

    // ======================================================================
    // read path
    // unknown filter bits read as zero so software sees a stable value
    always_comb begin
        rdata_d = 32'h0000_0000;

        unique case (acc)
            pevb_pkg::PEVB_ACC_FILTER: begin
                rdata_d[`PEVB_FLT_P] = flt_p_q;
                rdata_d[`PEVB_FLT_U] = flt_u_q;
                rdata_d[`PEVB_FLT_NSP] = flt_nsp_q;
                rdata_d[`PEVB_FLT_NSUSR] = flt_nsusr_q;
            end

            pevb_pkg::PEVB_ACC_EVTYPE: begin
                for (int i = 0; i < NUM_COUNTERS; i++) begin
                    if (ctr_idx == 5'(i)) begin
                        rdata_d[`PEVB_EVT_W-1:0] = evt_sel_q[i];
                    end
                end
            end

            pevb_pkg::PEVB_ACC_NONE: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // read data and hit stand for one cycle after the transfer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cp_hit_q <= 1'b0;
            cp_rdata_q <= 32'h0000_0000;
        end else begin
            cp_hit_q <= acc != pevb_pkg::PEVB_ACC_NONE;
            cp_rdata_q <= cp_write ? 32'h0000_0000 : rdata_d;
        end
    end

    // ======================================================================
    // cycle counter mode and state filter
    // the non-secure bits flip the meaning of P and U in non-secure state
    always_comb begin
        if (!cpu_nonsecure) begin
            allow_d = cpu_privileged ? !flt_p_q : !flt_u_q;
        end else if (cpu_privileged) begin
            allow_d = !(flt_p_q ^ flt_nsp_q);
        end else begin
            allow_d = !(flt_u_q ^ flt_nsusr_q);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cycle_count_allow_q <= 1'b0;
        end else begin
            cycle_count_allow_q <= allow_d;
        end
    end

    // ======================================================================
    // monitor interrupt
    // priority and masking belong to the external controller, so the
    // request is only registered and passed on
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= counter_overflow_irq;
        end
    end

    assign monitor_interrupt_out = irq_q;

endmodule

/* File: testbench/pevb_pipe_model.sv */
// ==========================================================================
// pipeline event sources: strobes launched one time unit after a rising edge
module pevb_pipe_model (
    // clock
    input wire logic clk_sys,
    // strobes and levels toward the block
    output logic [29:0] ev_q,
    output logic excl_q,
    output logic ra_q
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle sources drive low from time zero
    initial begin
        ev_q = 30'h0;
        excl_q = 1'b0;
        ra_q = 1'b0;
    end

    // one-cycle strobe of every source in m; exclusion qualifies the same cycle
    task automatic fire(input logic [29:0] m, input logic x);
        @(posedge clk_sys);
        #1;
        ev_q = m;
        excl_q = x;
        @(posedge clk_sys);
        #1;
        ev_q = 30'h0;
        excl_q = 1'b0;
    endtask

    // read-allocate mode is a level, not a strobe
    task automatic set_ra(input logic v);
        @(posedge clk_sys);
        #1;
        ra_q = v;
    endtask
endmodule

/* File: testbench/pevb_event_bus_monitor.sv */
`include "pevb_params.svh"

// ==========================================================================
// port checker for the event bus block
module pevb_event_bus_monitor #(
    parameter int NUM_COUNTERS = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // sources
    input wire logic ev_dtlb_refill,
    input wire logic ev_dtlb_refill_excluded,
    input wire logic ev_load_accepted,
    input wire logic ev_swap_accepted,
    input wire logic read_alloc_mode,
    input wire logic counter_overflow_irq,
    input wire logic [4:0] counter_select,
    // coprocessor port
    input wire logic cp_valid,
    input wire logic [3:0] cp_num,
    input wire logic [2:0] cp_opc1,
    input wire logic [3:0] cp_crn,
    input wire logic [3:0] cp_crm,
    input wire logic [2:0] cp_opc2,
    input wire logic cp_hit_q,
    input wire logic [31:0] cp_rdata_q,
    // results
    input wire pevb_pkg::pevb_bus_t event_pulse_bus,
    input wire logic monitor_interrupt_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // coordinates shared by filter and event type select
    logic coord_ok;
    assign coord_ok = cp_num == `PEVB_CP_NUM && cp_opc1 == `PEVB_CP_OPC1 &&
        cp_crn == `PEVB_CP_CRN && cp_crm == `PEVB_CP_CRM && cp_opc2 == `PEVB_CP_OPC2;

    sequence s_filter_req;
        cp_valid && coord_ok && counter_select == `PEVB_SEL_CYCLE;
    endsequence
    sequence s_ra_rise;
        !read_alloc_mode ##1 read_alloc_mode;
    endsequence

    // ======================================================================
    // assertions
    AST_RSVD_BIT: assert property (event_pulse_bus[28] == 1'b0)
        else $error("reserved event bit set");
    AST_LOAD_BIT: assert property (1'b1 |=>
        event_pulse_bus[5] == $past(ev_load_accepted | ev_swap_accepted))
        else $error("load bit mismatch");
    AST_DTLB_BIT: assert property (1'b1 |=>
        event_pulse_bus[4] == $past(ev_dtlb_refill & ~ev_dtlb_refill_excluded))
        else $error("tlb refill bit mismatch");
    AST_IRQ_OUT: assert property (counter_overflow_irq |=> monitor_interrupt_out)
        else $error("interrupt output missing");
    AST_RA_ENTER: assert property (s_ra_rise |=>
        event_pulse_bus[26] && event_pulse_bus[27] ##1 !event_pulse_bus[26])
        else $error("read allocate entry strobe wrong");
    AST_CP_HIT: assert property (s_filter_req |=> cp_hit_q)
        else $error("filter transfer not decoded");
    AST_CP_REFUSE: assert property (cp_valid && (!coord_ok ||
        (counter_select >= NUM_COUNTERS && counter_select != `PEVB_SEL_CYCLE)) |=>
        !cp_hit_q && cp_rdata_q == 32'h0)
        else $error("foreign transfer decoded");
    AST_FILTER_LOW: assert property (cp_hit_q && $past(counter_select) ==
        `PEVB_SEL_CYCLE |-> cp_rdata_q[27:0] == 28'h0)
        else $error("filter low bits not zero");
endmodule

bind pevb_event_bus pevb_event_bus_monitor #(.NUM_COUNTERS(NUM_COUNTERS)) u_mon (
    .clk_sys(clk_sys), .rst_n(rst_n), .ev_dtlb_refill(ev_dtlb_refill),
    .ev_dtlb_refill_excluded(ev_dtlb_refill_excluded), .ev_load_accepted(ev_load_accepted),
    .ev_swap_accepted(ev_swap_accepted), .read_alloc_mode(read_alloc_mode),
    .counter_overflow_irq(counter_overflow_irq), .counter_select(counter_select),
    .cp_valid(cp_valid), .cp_num(cp_num), .cp_opc1(cp_opc1), .cp_crn(cp_crn),
    .cp_crm(cp_crm), .cp_opc2(cp_opc2), .cp_hit_q(cp_hit_q), .cp_rdata_q(cp_rdata_q),
    .event_pulse_bus(event_pulse_bus), .monitor_interrupt_out(monitor_interrupt_out));

/* File: testbench/test_perf_event_bus_and_cycle_filter.sv */
`include "pevb_params.svh"

// ==========================================================================
// bench for the event bus and cycle filter block
module test_perf_event_bus_and_cycle_filter;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NC = 2;
    // bus bit of each source, in the order of the model's strobes
    localparam int POS [30] = '{0, 1, 2, 3, 4, 5, 6, 5, 7, 8, 8, 8, 9, 9, 9,
        10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 22, 22, 24, 25, 29};
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cpu_privileged = 1'b0;
    logic cpu_nonsecure = 1'b0;
    logic [4:0] counter_select = 5'h00;
    logic counter_overflow_irq = 1'b0;
    logic cp_valid = 1'b0;
    logic cp_write = 1'b0;
    logic [2:0] cp_opc2 = 3'h1;
    logic [3:0] cp_crm = 4'hd;
    logic [31:0] cp_wdata = 32'h0;
    logic cp_hit_q;
    logic [31:0] cp_rdata_q;
    pevb_pkg::pevb_bus_t event_pulse_bus;
    logic [NC-1:0] counter_event_q;
    logic cycle_count_allow_q;
    logic monitor_interrupt_out;
    logic [29:0] ev;
    logic excl;
    logic ra;
    int err_count = 0;
    int tests_run = 0;

    always #5 clk_sys = ~clk_sys;

    pevb_pipe_model pipe (.clk_sys(clk_sys), .ev_q(ev), .excl_q(excl), .ra_q(ra));

    // coprocessor number, opc1 and crn stay at the decoded values
    pevb_event_bus #(.NUM_COUNTERS(NC)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .ev_icache_refill(ev[0]), .ev_itlb_refill(ev[1]), .ev_dcache_refill(ev[2]),
        .ev_dcache_access(ev[3]), .ev_dtlb_refill(ev[4]), .ev_load_accepted(ev[5]),
        .ev_store_accepted(ev[6]), .ev_swap_accepted(ev[7]), .ev_instr_retired(ev[8]),
        .ev_exc_taken(ev[9]), .ev_irq_taken(ev[10]), .ev_fiq_taken(ev[11]),
        .ev_load_multiple_pc_user(ev[12]), .ev_return_from_exception(ev[13]),
        .ev_dp_flags_pc_write(ev[14]), .ev_context_id_write(ev[15]), .ev_pc_write(ev[16]),
        .ev_imm_branch(ev[17]), .ev_proc_return(ev[18]), .ev_unaligned(ev[19]),
        .ev_branch_mispredict(ev[20]), .ev_branch_predictable(ev[21]),
        .ev_dmem_access(ev[22]), .ev_icache_access(ev[23]), .ev_dcache_evict(ev[24]),
        .ev_ext_request(ev[25]), .ev_ext_noncacheable(ev[26]), .ev_prefetch_fill(ev[27]),
        .ev_prefetch_drop(ev[28]), .ev_store_buffer_stall(ev[29]),
        .ev_dtlb_refill_excluded(excl), .read_alloc_mode(ra),
        .cpu_privileged(cpu_privileged), .cpu_nonsecure(cpu_nonsecure),
        .counter_select(counter_select), .counter_overflow_irq(counter_overflow_irq),
        .cp_valid(cp_valid), .cp_write(cp_write), .cp_num(`PEVB_CP_NUM),
        .cp_opc1(`PEVB_CP_OPC1), .cp_crn(`PEVB_CP_CRN), .cp_crm(cp_crm),
        .cp_opc2(cp_opc2), .cp_wdata(cp_wdata), .cp_hit_q(cp_hit_q), .cp_rdata_q(cp_rdata_q),
        .event_pulse_bus(event_pulse_bus), .counter_event_q(counter_event_q),
        .cycle_count_allow_q(cycle_count_allow_q),
        .monitor_interrupt_out(monitor_interrupt_out));

    // ======================================================================
    // helpers
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask

    task automatic cp_acc(input logic w, input logic [4:0] sel, input logic [2:0] o2,
                          input logic [31:0] wd, output logic h, output logic [31:0] rd);
        @(posedge clk_sys);
        #1;
        cp_valid = 1'b1;
        cp_write = w;
        counter_select = sel;
        cp_opc2 = o2;
        cp_wdata = wd;
        @(posedge clk_sys);
        #1;
        h = cp_hit_q;
        rd = cp_rdata_q;
        cp_valid = 1'b0;
    endtask

    // expected hit and data of one transfer on the shared coordinate
    task automatic xfer(input logic w, input logic [4:0] sel, input logic [2:0] o2,
                        input logic [31:0] wd, input logic eh, input logic [31:0] erd);
        logic h;
        logic [31:0] rd;
        cp_acc(w, sel, o2, wd, h, rd);
        chk("cp_hit", 32'(eh), 32'(h));
        chk("cp_rdata", erd, rd);
    endtask

    // bus image of a set of sources, exclusions applied
    function automatic logic [29:0] exp_bus(input logic [29:0] m, input logic x);
        logic [29:0] b;
        b = 30'h0;
        for (int i = 0; i < 30; i++) begin
            if (m[i]) b[POS[i]] = 1'b1;
        end
        if (m[7]) b[6] = 1'b1;
        if (m[10]) b[20] = 1'b1;
        if (m[11]) b[21] = 1'b1;
        if (m[26]) b[23] = 1'b1;
        if (x) b[4] = 1'b0;
        if (m[12] | m[13] | m[14]) b[13] = 1'b0;
        return b;
    endfunction

    // pulse for exactly one cycle, then the counter strobe one cycle later
    task automatic ev_case(input logic [29:0] m, input logic x);
        logic [29:0] e;
        e = exp_bus(m, x);
        pipe.fire(m, x);
        chk("event_pulse_bus", 32'(e), 32'(event_pulse_bus));
        @(posedge clk_sys);
        #1;
        chk("event_pulse_bus idle", 32'h0, 32'(event_pulse_bus));
        chk("counter_event_q", 32'({1'b0, e[5]}), 32'(counter_event_q));
    endtask

    function automatic logic allow(input logic [3:0] f, input logic [1:0] s);
        if (!s[1]) return s[0] ? !f[3] : !f[2];
        return s[0] ? !(f[3] ^ f[1]) : !(f[2] ^ f[0]);
    endfunction

    task automatic print_verdict();
        $display("counts: %0d checks, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ======================================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        #1;
        chk("reset bus", 32'h0, 32'(event_pulse_bus));
        chk("reset irq", 32'h0, 32'(monitor_interrupt_out));
        rst_n = 1'b1;
        xfer(1'b0, 5'h1f, 3'h1, 32'h0, 1'b1, 32'h0);
        xfer(1'b0, 5'h00, 3'h1, 32'h0, 1'b1, 32'h0);
        $display("test reset done");
        // counter 0 follows loads, counter 1 a reserved number
        xfer(1'b1, 5'h00, 3'h1, 32'h0000_0006, 1'b1, 32'h0);
        xfer(1'b1, 5'h01, 3'h1, 32'hffff_ffc6, 1'b1, 32'h0);
        xfer(1'b0, 5'h01, 3'h1, 32'h0, 1'b1, 32'h0000_00c6);
        for (int i = 0; i < 30; i++) begin
            ev_case(30'h1 << i, 1'b0);
        end
        ev_case(30'h0000_0010, 1'b1);
        ev_case(30'h0004_2000, 1'b0);
        $display("test events done");
        pipe.set_ra(1'b1);
        @(posedge clk_sys);
        #1;
        chk("ra enter", 32'h0c00_0000, 32'(event_pulse_bus));
        @(posedge clk_sys);
        #1;
        chk("ra mode", 32'h0800_0000, 32'(event_pulse_bus));
        pipe.set_ra(1'b0);
        $display("test read allocate done");
        // written in one security state, read in the other: one shared copy
        cpu_nonsecure = 1'b1;
        xfer(1'b1, 5'h1f, 3'h1, 32'h5fff_ffff, 1'b1, 32'h0);
        cpu_nonsecure = 1'b0;
        xfer(1'b0, 5'h1f, 3'h1, 32'h0, 1'b1, 32'h5000_0000);
        xfer(1'b1, 5'h1f, 3'h0, 32'ha000_0000, 1'b0, 32'h0);
        xfer(1'b1, 5'h02, 3'h1, 32'ha000_0000, 1'b0, 32'h0);
        cp_crm = 4'hc;
        xfer(1'b1, 5'h1f, 3'h1, 32'ha000_0000, 1'b0, 32'h0);
        cp_crm = 4'hd;
        xfer(1'b0, 5'h1f, 3'h1, 32'h0, 1'b1, 32'h5000_0000);
        for (int f = 0; f < 16; f++) begin
            xfer(1'b1, 5'h1f, 3'h1, {f[3:0], 28'h0}, 1'b1, 32'h0);
            for (int s = 0; s < 4; s++) begin
                @(posedge clk_sys);
                #1;
                cpu_privileged = s[0];
                cpu_nonsecure = s[1];
                @(posedge clk_sys);
                #1;
                chk("allow", 32'(allow(f[3:0], s[1:0])), 32'(cycle_count_allow_q));
            end
        end
        $display("test filter done");
        @(posedge clk_sys);
        #1;
        counter_overflow_irq = 1'b1;
        @(posedge clk_sys);
        #1;
        chk("irq high", 32'h1, 32'(monitor_interrupt_out));
        counter_overflow_irq = 1'b0;
        @(posedge clk_sys);
        #1;
        chk("irq low", 32'h0, 32'(monitor_interrupt_out));
        $display("test interrupt done");
        print_verdict();
    end

    // the tests need about three hundred cycles; over thirty times that means a hang
    initial begin
        #100us;
        err_count++;
        print_verdict();
    end
endmodule
